// File: dv/sew_master.sv
// Behavioural two-wire bus master with pull-up on the data wire.
// Assumes clk from the bench; steps on falling clk edges, under 1 MHz bit rate.
`timescale 1ns/10ps
module sew_master (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_i
);
	logic pull_low = 1'b0;
	initial scl = 1'b1;
	// Wire level: high by pull-up unless a party pulls it low
	assign sda_i = ~(pull_low | sda_oe);
	task automatic hp();
		repeat (20) @(negedge clk);
	endtask
	// Idle clock pulses with data released, for reset
	task automatic clocks();
		repeat (4) begin
			scl = 1'b0;
			hp();
			scl = 1'b1;
			hp();
		end
	endtask
	// Start: data falls while clock high
	task automatic start();
		repeat (4) @(negedge clk);
		pull_low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		pull_low = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	// Stop: data rises while clock high, then bus free time
	task automatic stop();
		repeat (4) @(negedge clk);
		pull_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		pull_low = 1'b0;
		hp();
	endtask
	// One bit slot; data moves only while clock low
	task automatic bit_io(logic b, output logic r);
		repeat (4) @(negedge clk);
		pull_low = ~b;
		hp();
		scl = 1'b1;
		hp();
		r = sda_i;
		scl = 1'b0;
	endtask
	// Byte out MSB first, then release for the acknowledge slot
	task automatic send(logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Byte in, then acknowledge to continue or release to end
	task automatic recv(logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(~more, r);
	endtask
endmodule

// File: dv/sew_top_sva.sv
// Concurrent checks on the serial EEPROM target's top-level ports.
// Assumes binding to sew_top; all checks run on clk with rst_b low as reset.
`timescale 1ns/10ps
module sew_top_sva #(
	parameter int PROG_CYCLES = sew_pkg::WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic write_protect_in,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic prog_busy
);
	int busy_cnt_reg;
	// Counts the cycles of the running programming cycle
	always_ff @(posedge clk) begin
		if (!rst_b || !prog_busy)
			busy_cnt_reg <= 0;
		else
			busy_cnt_reg <= busy_cnt_reg + 1;
	end
	// ----------------------------------------
	// Port checks
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_drain_only: assert property (sda_o == 1'b0) else $error("sda driven high");
	a_reset_quiet: assert property ($rose(rst_b) |-> !sda_oe && !prog_busy) else $error("active after reset");
	a_busy_length: assert property ($fell(prog_busy) |-> busy_cnt_reg == PROG_CYCLES) else $error("busy length");
	a_busy_bound: assert property (prog_busy |-> busy_cnt_reg < PROG_CYCLES) else $error("busy too long");
	a_busy_silent: assert property (prog_busy |-> !sda_oe) else $error("pull while busy");
	a_protect_no_prog: assert property ($rose(prog_busy) |-> !write_protect_in) else $error("program protected");
	a_prog_after_stop: assert property ($rose(prog_busy) |-> scl && sda_i) else $error("program not at stop");
	a_oe_clock_low: assert property ($changed(sda_oe) |-> !scl) else $error("sda moved, scl high");
	a_start_quiet: assert property (scl && $fell(sda_i) |-> !sda_oe [*8]) else $error("pull at start");
	c_prog: cover property ($rose(prog_busy));
	c_protect_ack: cover property (write_protect_in && $rose(sda_oe));
	c_busy_clock: cover property (prog_busy && $rose(scl));
endmodule
bind sew_top sew_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i),
	.write_protect_in(write_protect_in), .sda_o(sda_o), .sda_oe(sda_oe), .prog_busy(prog_busy));

// File: dv/tb_top.sv
// Self-checking bench for the serial EEPROM target.
// Assumes sew_master as bus partner and a short programming cycle.
`timescale 1ns/10ps
module tb_top;
	// Long enough that a select sent right after a stop still meets a busy target
	localparam int PROG = 1000;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp = 1'b0;
	wire scl;
	wire sda_i;
	wire sda_o;
	wire sda_oe;
	wire prog_busy;
	int num_errors = 0;
	int n_tests = 0;
	always #12.5 clk = ~clk;
	sew_top #(.PROG_CYCLES(PROG)) uut (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i),
		.write_protect_in(wp), .sda_o(sda_o), .sda_oe(sda_oe), .prog_busy(prog_busy));
	sew_master bus (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_i(sda_i));
	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Single-bit compare for acknowledges and flags
	task automatic chk_bit(string what, logic exp, logic got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Single-byte write, then programming check and wait
	task automatic wr(logic [7:0] sel, logic [7:0] adr, logic [7:0] d, logic dack);
		logic a;
		bus.start();
		bus.send(sel, a);
		chk_bit("select ack", 1'h1, a);
		bus.send(adr, a);
		chk_bit("address ack", 1'h1, a);
		bus.send(d, a);
		chk_bit("data ack", dack, a);
		bus.stop();
		chk_bit("prog busy", dack, prog_busy);
		repeat (PROG + 4) @(negedge clk);
	endtask
	// Random read of one or two bytes
	task automatic rd(logic [7:0] sel, logic [7:0] adr, logic two, output logic [7:0] d0, output logic [7:0] d1);
		logic a;
		bus.start();
		bus.send(sel, a);
		bus.send(adr, a);
		bus.start();
		bus.send(sel | 8'h01, a);
		bus.recv(two, d0);
		if (two)
			bus.recv(1'b0, d1);
		bus.stop();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk_bit("sda_o", 1'h0, sda_o);
		chk_bit("sda_oe", 1'h0, sda_oe);
	endtask
	task automatic t_write_read();
		logic [7:0] d0;
		logic [7:0] d1;
		wr(8'hAE, 8'h0F, 8'h3C, 1'h1);
		wr(8'hAE, 8'h0E, 8'hC5, 1'h1);
		wr(8'hAE, 8'h0F, 8'h81, 1'h1);
		rd(8'hAE, 8'h0E, 1'h1, d0, d1);
		chk("byte 70E", 8'hC5, d0);
		chk("byte 70F", 8'h81, d1);
	endtask
	task automatic t_protect();
		logic [7:0] d0;
		logic [7:0] d1;
		wp = 1'b1;
		wr(8'hAE, 8'h0F, 8'h55, 1'h0);
		wp = 1'b0;
		rd(8'hAE, 8'h0F, 1'h0, d0, d1);
		chk("kept byte", 8'h81, d0);
	endtask
	task automatic t_refuse();
		logic a;
		bus.start();
		bus.send(8'h90, a);
		chk_bit("bad type ack", 1'h0, a);
		bus.stop();
		bus.start();
		bus.send(8'hA0, a);
		bus.send(8'h01, a);
		bus.send(8'h77, a);
		bus.stop();
		bus.start();
		bus.send(8'hA0, a);
		chk_bit("busy select ack", 1'h0, a);
		bus.stop();
		repeat (PROG) @(negedge clk);
	endtask
	task automatic t_id_page();
		logic [7:0] d0;
		logic [7:0] d1;
		wr(8'hB0, 8'h02, 8'h5A, 1'h1);
		wr(8'hB0, 8'h80, 8'h00, 1'h1);
		wr(8'hB0, 8'h02, 8'hA5, 1'h0);
		rd(8'hB0, 8'h02, 1'h0, d0, d1);
		chk("id byte", 8'h5A, d0);
	endtask
	// Hang guard: the sequence needs about 26k clocks, this allows 60k
	initial begin
		#1500000;
		num_errors++;
		report_and_stop();
	end
	// Reset with idle clock pulses, then the scenarios
	initial begin
		repeat (10) @(negedge clk);
		bus.clocks();
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_write_read();
		t_protect();
		t_refuse();
		t_id_page();
		report_and_stop();
	end
endmodule

// File: shared/sew_ecc_if.sv
// Carrier between the core and its error-correction codec.
// Assumes a purely combinational codec on the far side.
`timescale 1ns/10ps
interface sew_ecc_if;
	logic [sew_pkg::DATA_W-1:0] enc_data;
	logic [sew_pkg::CW_W-1:0] enc_code;
	logic [sew_pkg::CW_W-1:0] dec_code;
	logic [sew_pkg::DATA_W-1:0] dec_data;
	modport codec(input enc_data, input dec_code, output enc_code, output dec_data);
	modport user(output enc_data, output dec_code, input enc_code, input dec_data);
endinterface

// File: shared/sew_pkg.sv
// Constants, field layouts and states of the serial EEPROM target.
// Assumes nothing of its surroundings; shared by the core and its codec.
package sew_pkg;
	// ----------------------------------------
	// Geometry of the storage
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int MEM_BYTES = 2048;
	localparam int PAGES = 128;
	localparam int PAGE_BYTES = 16;
	localparam int ADDR_W = 11;
	localparam int PAGE_W = 4;
	localparam int CW_W = 12;
	localparam int PAR_W = 4;
	// ----------------------------------------
	// Select byte and address byte fields
	// ----------------------------------------
	localparam logic [3:0] TYPE_MEM = 4'hA;
	localparam logic [3:0] TYPE_IDP = 4'hB;
	localparam int LOCK_ADDR_BIT = 7;
	localparam int HI_ADDR_LSB = 8;
	localparam int LO_ADDR_W = 8;
	// ----------------------------------------
	// Bit slot counting on the serial link
	// ----------------------------------------
	localparam int BIT_LAST = 7;
	localparam int ACK_SLOT = 8;
	localparam int CNT_AFTER_START = 2;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int F_SCL_MAX_KHZ = 1000;
	localparam int T_WRITE_MS = 4;
	localparam int WRITE_CYCLES = T_WRITE_MS * 1000 * CLK_MHZ;
	// ----------------------------------------
	// Link state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SEL = 3'h1,
		ST_ADDR = 3'h2,
		ST_WDATA = 3'h3,
		ST_READ = 3'h4
	} sew_state_e;
endpackage

// File: src/sew_ecc.sv
// Single-error-correcting Hamming codec for one byte, 12-bit codewords.
// Assumes the user drives both inputs; no clock, no state.
`timescale 1ns/10ps
module sew_ecc (
	sew_ecc_if.codec ecc
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Places data bits at the non power-of-two positions
	function automatic logic [sew_pkg::CW_W-1:0] spread(input logic [sew_pkg::DATA_W-1:0] d);
		logic [sew_pkg::CW_W-1:0] cw;
		int k;
		cw = '0;
		k = 0;
		for (int p = 1; p <= sew_pkg::CW_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p-1] = d[k];
				k++;
			end
		end
		return cw;
	endfunction

	// Xor of the positions of all set bits
	function automatic logic [sew_pkg::PAR_W-1:0] syndrome(input logic [sew_pkg::CW_W-1:0] cw);
		logic [sew_pkg::PAR_W-1:0] s;
		s = '0;
		for (int p = 1; p <= sew_pkg::CW_W; p++) begin
			if (cw[p-1]) begin
				s = s ^ sew_pkg::PAR_W'(p);
			end
		end
		return s;
	endfunction

	// Pulls the data bits back out of a codeword
	function automatic logic [sew_pkg::DATA_W-1:0] gather(input logic [sew_pkg::CW_W-1:0] cw);
		logic [sew_pkg::DATA_W-1:0] d;
		int k;
		d = '0;
		k = 0;
		for (int p = 1; p <= sew_pkg::CW_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = cw[p-1];
				k++;
			end
		end
		return d;
	endfunction

	// ----------------------------------------
	// Encode and correct
	// ----------------------------------------
	// Parity bits take the syndrome so the whole word checks to zero
	always_comb begin
		logic [sew_pkg::CW_W-1:0] cw;
		logic [sew_pkg::PAR_W-1:0] s;
		cw = spread(ecc.enc_data);
		s = syndrome(cw);
		for (int b = 0; b < sew_pkg::PAR_W; b++) begin
			cw[(1 << b) - 1] = s[b];
		end
		ecc.enc_code = cw;
	end

	// A nonzero syndrome names the single flipped position
	always_comb begin
		logic [sew_pkg::CW_W-1:0] cw;
		logic [sew_pkg::PAR_W-1:0] s;
		cw = ecc.dec_code;
		s = syndrome(cw);
		if (s != '0 && int'(s) <= sew_pkg::CW_W) begin
			cw[s - 1'b1] = ~cw[s - 1'b1];
		end
		ecc.dec_data = gather(cw);
	end
endmodule

// File: src/sew_top.sv
// Two-wire serial EEPROM target: 2048-byte array, lockable identification page.
// Assumes an external master on scl/sda, a pull-up on sda and a pull-down on write_protect_in.
`timescale 1ns/10ps
// Functional notes
// - Array of 2048 bytes, 128 pages of 16 bytes.
// - Each byte written on its own, neighbours of the page untouched.
// - Stored bytes carry a Hamming code, reads are corrected silently.
// - Sixteen-byte identification page, read-only once locked until rst_b clears the lock.
// - Works with serial clock up to 1 MHz; master stays below it except for its reset pulses at 1 MHz.
// - Serial clock rises capture data, falls launch driven bits.
// - Data line only pulled low or released, never driven high.
// - Write protect high blocks every change to the array.
// - Write protect low or floating allows writes.
// - Under write protect, select and address acked, data bytes not.
// - Start is data falling while clock high; it restarts decoding.
// - Stop is data rising while clock high; after a write it programs.
// - Receiver pulls data low in the ninth slot to acknowledge.
// - Select byte: type 1010/1011, three high address bits, direction bit.
module sew_top #(
	parameter int PROG_CYCLES = sew_pkg::WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic write_protect_in,
	output logic sda_o,
	output logic sda_oe,
	output logic prog_busy
);
	localparam int PC_W = $clog2(PROG_CYCLES + 1);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [sew_pkg::CW_W-1:0] mem [sew_pkg::MEM_BYTES];
	logic [sew_pkg::CW_W-1:0] idp_mem [sew_pkg::PAGE_BYTES];
	logic [sew_pkg::DATA_W-1:0] pbuf [sew_pkg::PAGE_BYTES];

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic wpc_m, wpc_s, pend_m, pend_s, drv_m, drv_s;
	logic start_tgl_reg, committed_reg, busy_reg, lock_reg;
	logic [PC_W-1:0] pc_reg;
	logic st_m, st_s, st_d, busy_ms, busy_ss, lock_ms, lock_ss, wp_m, wp_s, rs_m, rs_s;
	logic sda_smp;
	sew_pkg::sew_state_e st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [sew_pkg::BIT_LAST-1:0] shreg_reg, shreg_next;
	logic [sew_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic idp_reg, idp_next, lock_op_reg, lock_op_next;
	logic [sew_pkg::DATA_W-1:0] tx_reg, tx_next;
	logic drive_reg, drive_next, pend_reg, pend_next, buf_we;
	logic [sew_pkg::PAGE_BYTES-1:0] mask_reg, mask_next;
	sew_ecc_if ecc_bus ();

	sew_ecc u_ecc (
		.ecc(ecc_bus)
	);

	// ----------------------------------------
	// Pin sampling and bus conditions on clk
	// ----------------------------------------
	// Two stages per pin, a third for edge detection
	always_ff @(posedge clk) begin
		{scl_m, scl_s, scl_d} <= {scl, scl_m, scl_s};
		{sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
		{wpc_m, wpc_s} <= {write_protect_in, wpc_m};
		{pend_m, pend_s} <= {pend_reg, pend_m};
		{drv_m, drv_s} <= {drive_reg, drv_m};
	end

	// Oversampling at 40 MHz resolves a 1 MHz serial clock
	wire scl_high = scl_s & scl_d;
	wire start_det = scl_high & sda_d & ~sda_s;
	wire stop_det = scl_high & ~sda_d & sda_s;

	// ----------------------------------------
	// Programming cycle on clk
	// ----------------------------------------
	// Page contents are static after stop, so the clk side reads them directly
	wire commit_go = stop_det & pend_s & ~committed_reg & ~busy_reg;
	wire pc_last = pc_reg == PC_W'(PROG_CYCLES - 1);
	wire [sew_pkg::PAGE_W-1:0] slot = pc_reg[sew_pkg::PAGE_W-1:0];
	wire slot_live = busy_reg & (pc_reg < PC_W'(sew_pkg::PAGE_BYTES));
	wire lock_req = idp_reg & lock_op_reg;
	wire wr_en = slot_live & mask_reg[slot] & ~lock_req & ~wpc_s & ~(idp_reg & lock_reg);
	wire lock_now = busy_reg & (pc_reg == '0) & lock_req & ~wpc_s;
	wire [sew_pkg::ADDR_W-1:0] wr_addr = {addr_reg[sew_pkg::ADDR_W-1:sew_pkg::PAGE_W], slot};
	assign ecc_bus.enc_data = pbuf[slot];

	// Commit sequencer, lock flag and busy timer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{start_tgl_reg, committed_reg, busy_reg, lock_reg} <= 4'h0;
			pc_reg <= '0;
		end else begin
			start_tgl_reg <= start_tgl_reg ^ start_det;
			committed_reg <= pend_s & (committed_reg | commit_go);
			busy_reg <= commit_go | (busy_reg & ~pc_last);
			pc_reg <= commit_go ? '0 : (busy_reg ? pc_reg + 1'b1 : pc_reg);
			lock_reg <= lock_reg | lock_now;
		end
	end

	// Encoded bytes go in one per cycle during the programming cycle
	always_ff @(posedge clk) begin
		if (wr_en && !idp_reg) begin
			mem[wr_addr] <= ecc_bus.enc_code;
		end
		if (wr_en && idp_reg) begin
			idp_mem[slot] <= ecc_bus.enc_code;
		end
	end

	// Outputs: sda open drain, only ever pulled low; prog_busy follows busy_reg
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{sda_o, sda_oe, prog_busy} <= 3'h0;
		end else begin
			sda_o <= 1'b0;
			sda_oe <= drv_s;
			prog_busy <= busy_reg;
		end
	end

	// ----------------------------------------
	// Link side on the serial clock
	// ----------------------------------------
	// Data is sampled on the rising edge
	always_ff @(posedge scl) begin
		sda_smp <= sda_i;
	end

	// Level crossings into the serial clock domain
	always_ff @(negedge scl) begin
		{st_m, st_s, st_d} <= {start_tgl_reg, st_m, st_s};
		{busy_ms, busy_ss} <= {busy_reg, busy_ms};
		{lock_ms, lock_ss} <= {lock_reg, lock_ms};
		{wp_m, wp_s} <= {write_protect_in, wp_m};
		{rs_m, rs_s} <= {rst_b, rs_m};
	end

	// Arrays do not change while the bus is served, so this read is static
	assign ecc_bus.dec_code = idp_reg ? idp_mem[addr_reg[sew_pkg::PAGE_W-1:0]] : mem[addr_reg];
	wire [sew_pkg::DATA_W-1:0] rd_data = ecc_bus.dec_data;

	// Decoding of the byte in flight
	wire [sew_pkg::DATA_W-1:0] rx_byte = {shreg_reg, sda_smp};
	wire start_new = st_s != st_d;
	wire byte_end = cnt_reg == 4'(sew_pkg::BIT_LAST);
	wire ack_end = cnt_reg == 4'(sew_pkg::ACK_SLOT);
	wire [3:0] sel_type = rx_byte[sew_pkg::DATA_W-1:sew_pkg::DATA_W-4];
	wire sel_idp = sel_type == sew_pkg::TYPE_IDP;
	wire sel_hit = (sel_type == sew_pkg::TYPE_MEM | sel_idp) & ~busy_ss;
	wire data_ok = ~wp_s & ~(idp_reg & lock_ss);
	wire [sew_pkg::PAGE_W-1:0] lo_inc = addr_reg[sew_pkg::PAGE_W-1:0] + 1'b1;
	wire [sew_pkg::ADDR_W-1:0] page_inc = {addr_reg[sew_pkg::ADDR_W-1:sew_pkg::PAGE_W], lo_inc};
	wire [sew_pkg::ADDR_W-1:0] read_inc = idp_reg ? page_inc : addr_reg + 1'b1;
	wire [2:0] tx_idx = 3'(sew_pkg::BIT_LAST - 1) - cnt_reg[2:0];

	// Byte, acknowledge and transmit sequencing, evaluated on each falling edge
	always_comb begin
		st_next = st_reg;
		cnt_next = ack_end ? 4'h0 : cnt_reg + 4'h1;
		shreg_next = rx_byte[sew_pkg::BIT_LAST-1:0];
		addr_next = addr_reg;
		idp_next = idp_reg;
		lock_op_next = lock_op_reg;
		tx_next = tx_reg;
		drive_next = 1'b0;
		pend_next = pend_reg;
		mask_next = mask_reg;
		buf_we = 1'b0;
		if (start_new) begin
			st_next = sew_pkg::ST_SEL;
			cnt_next = 4'(sew_pkg::CNT_AFTER_START);
		end else begin
			unique case (st_reg)
				sew_pkg::ST_IDLE: begin
				end
				sew_pkg::ST_SEL: begin
					if (byte_end && sel_hit) begin
						drive_next = 1'b1;
						idp_next = sel_idp;
						pend_next = 1'b0;
						mask_next = '0;
						if (!sel_idp) begin
							addr_next[sew_pkg::ADDR_W-1:sew_pkg::HI_ADDR_LSB] = rx_byte[3:1];
						end
						st_next = rx_byte[0] ? sew_pkg::ST_READ : sew_pkg::ST_ADDR;
					end else if (byte_end) begin
						st_next = sew_pkg::ST_IDLE;
					end
				end
				sew_pkg::ST_ADDR: begin
					if (byte_end) begin
						drive_next = 1'b1;
						lock_op_next = rx_byte[sew_pkg::LOCK_ADDR_BIT];
						addr_next[sew_pkg::LO_ADDR_W-1:0] = rx_byte;
						st_next = sew_pkg::ST_WDATA;
					end
				end
				sew_pkg::ST_WDATA: begin
					if (byte_end && data_ok) begin
						drive_next = 1'b1;
						buf_we = 1'b1;
						mask_next[addr_reg[sew_pkg::PAGE_W-1:0]] = 1'b1;
						pend_next = 1'b1;
						addr_next = page_inc;
					end
				end
				sew_pkg::ST_READ: begin
					// Our own ack after select reads back low, so it starts the first byte
					if (byte_end) begin
						addr_next = read_inc;
					end else if (ack_end && !sda_smp) begin
						tx_next = rd_data;
						drive_next = ~rd_data[sew_pkg::BIT_LAST];
					end else if (ack_end) begin
						st_next = sew_pkg::ST_IDLE;
					end else begin
						drive_next = ~tx_reg[tx_idx];
					end
				end
				default: begin
					st_next = sew_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Link state registers, launched on the falling edge
	always_ff @(negedge scl) begin
		if (!rs_s) begin
			st_reg <= sew_pkg::ST_IDLE;
			{cnt_reg, drive_reg, pend_reg} <= 6'h00;
			mask_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			drive_reg <= drive_next;
			pend_reg <= pend_next;
			mask_reg <= mask_next;
		end
	end

	// Data path registers of the link
	always_ff @(negedge scl) begin
		shreg_reg <= shreg_next;
		addr_reg <= addr_next;
		idp_reg <= idp_next;
		lock_op_reg <= lock_op_next;
		tx_reg <= tx_next;
	end

	// Page buffer fills byte by byte
	always_ff @(negedge scl) begin
		if (buf_we) begin
			pbuf[addr_reg[sew_pkg::PAGE_W-1:0]] <= rx_byte;
		end
	end
endmodule
